//--- hdl/pcs_clock_status.v
/*
 * Clock generator status and flag block with an AXI4-Lite slave.
 * Assumes pll and oscillator status inputs synchronous to aclk, and a
 * one-cycle low_voltage_reset_event pulse from the supply monitor.
 */
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pcs_regs.vh"

module pcs_clock_status #(
	parameter HAS_LVR = 1
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire pll_locked,
	input wire pll_tracking,
	input wire self_clock_mode,
	input wire low_voltage_reset_event,
	output reg irq
);
	reg low_voltage_reset_flag;
	reg pll_lock_change_flag;
	reg self_clock_change_flag;
	reg pll_lock_change_irq_enable;
	reg self_clock_change_irq_enable;
	reg [7:0] irq_status;
	reg [7:0] irq_mask;
	reg [7:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;
	reg lock_status;
	reg track_status;
	reg self_clock_mode_status;
	wire [1:0] changed;
	wire wr_go;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire wr_lane0;
	wire wr_flags;
	wire wr_enable;
	wire wr_status;
	wire wr_mask;
	wire [7:0] clock_generator_flags;
	wire [7:0] irq_events;
	wire [7:0] next_irq_status;
	reg [31:0] next_rdata;
	reg next_rerr;

	// Status bits are registered; the change pulses follow them one cycle later
	always @(posedge aclk) begin
		if (!aresetn) begin
			lock_status <= 1'b0;
			track_status <= 1'b0;
			self_clock_mode_status <= 1'b0;
		end else begin
			lock_status <= pll_locked & ~self_clock_mode;
			track_status <= pll_tracking & ~self_clock_mode;
			self_clock_mode_status <= self_clock_mode;
		end
	end

	pcs_change_detect #(
		.WIDTH(2)
	) u_change (
		.aclk(aclk),
		.aresetn(aresetn),
		.level({self_clock_mode_status, lock_status}),
		.changed(changed)
	);

	assign clock_generator_flags = {2'b00, low_voltage_reset_flag, pll_lock_change_flag,
		lock_status, track_status, self_clock_change_flag, self_clock_mode_status};

	// Write path: address and data may arrive in either order
	assign wr_go = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid) & ~s_axi_bvalid;
	assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	assign wr_data = w_held ? w_data : s_axi_wdata;
	assign wr_lane0 = wr_go & (w_held ? w_strb[0] : s_axi_wstrb[0]);
	assign wr_flags = wr_lane0 & (wr_addr == `PCS_OFF_FLAGS);
	assign wr_enable = wr_lane0 & (wr_addr == `PCS_OFF_ENABLE);
	assign wr_status = wr_lane0 & (wr_addr == `PCS_OFF_IRQ_STATUS);
	assign wr_mask = wr_lane0 & (wr_addr == `PCS_OFF_IRQ_MASK);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PCS_RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid & ~aw_held & ~s_axi_awready & ~s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid & ~w_held & ~s_axi_wready & ~s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held & w_held & ~s_axi_bvalid) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `PCS_OFF_FLAGS || aw_addr == `PCS_OFF_ENABLE ||
					aw_addr == `PCS_OFF_IRQ_STATUS || aw_addr == `PCS_OFF_IRQ_MASK) ?
					`PCS_RESP_OKAY : `PCS_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Flags commit only once both halves are held, so no early side effects
	wire commit = aw_held & w_held & ~s_axi_bvalid & w_strb[0];
	wire c_flags = commit & (aw_addr == `PCS_OFF_FLAGS);
	wire c_enable = commit & (aw_addr == `PCS_OFF_ENABLE);
	wire c_status = commit & (aw_addr == `PCS_OFF_IRQ_STATUS);
	wire c_mask = commit & (aw_addr == `PCS_OFF_IRQ_MASK);

	always @(posedge aclk) begin
		if (!aresetn) begin
			low_voltage_reset_flag <= 1'b0;
			pll_lock_change_flag <= 1'b0;
			self_clock_change_flag <= 1'b0;
			pll_lock_change_irq_enable <= 1'b0;
			self_clock_change_irq_enable <= 1'b0;
		end else begin
			if (HAS_LVR == 0) begin
				low_voltage_reset_flag <= 1'b0;
			end else if (low_voltage_reset_event) begin
				low_voltage_reset_flag <= 1'b1;
			end else if (c_flags & w_data[`PCS_BIT_LVR]) begin
				low_voltage_reset_flag <= 1'b0;
			end
			if (changed[0]) begin
				pll_lock_change_flag <= 1'b1;
			end else if (c_flags & w_data[`PCS_BIT_PLL_LOCK_CHANGE_FLAG]) begin
				pll_lock_change_flag <= 1'b0;
			end
			if (changed[1]) begin
				self_clock_change_flag <= 1'b1;
			end else if (c_flags & w_data[`PCS_BIT_SELF_CLOCK_CHANGE_FLAG]) begin
				self_clock_change_flag <= 1'b0;
			end
			if (c_enable) begin
				pll_lock_change_irq_enable <= w_data[`PCS_BIT_EN_LOCK];
				self_clock_change_irq_enable <= w_data[`PCS_BIT_EN_SCM];
			end
		end
	end

	// Sticky event copy for the mask/status pair, same layout as flags
	assign irq_events = {2'b00, (HAS_LVR != 0) & low_voltage_reset_event, changed[0],
		1'b0, 1'b0, changed[1], 1'b0};
	assign next_irq_status = (irq_status & ~({8{c_status}} & w_data[7:0])) | irq_events;

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= 8'h00;
			irq_mask <= `PCS_MASK_RESET;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (c_mask) begin
				irq_mask <= w_data[7:0];
			end
			// Level request held while any enabled flag is set
			irq <= (pll_lock_change_flag & pll_lock_change_irq_enable) |
				(self_clock_change_flag & self_clock_change_irq_enable) |
				(|(irq_status & irq_mask));
		end
	end

	// Read path
	always @* begin
		next_rdata = 32'h00000000;
		next_rerr = 1'b0;
		case (s_axi_araddr)
			`PCS_OFF_FLAGS: next_rdata = {24'h000000, clock_generator_flags};
			`PCS_OFF_ENABLE: next_rdata = {30'h00000000, self_clock_change_irq_enable,
				pll_lock_change_irq_enable};
			`PCS_OFF_IRQ_STATUS: next_rdata = {24'h000000, irq_status};
			`PCS_OFF_IRQ_MASK: next_rdata = {24'h000000, irq_mask};
			default: next_rerr = 1'b1;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PCS_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rerr ? `PCS_RESP_SLVERR : `PCS_RESP_OKAY;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

//--- hdl/pcs_regs.vh
/*
 * Register offsets, field positions and reset values of the clock status
 * and flag block. Assumes inclusion by bare name from the design files.
 */
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

`define PCS_OFF_FLAGS 8'h00
`define PCS_OFF_ENABLE 8'h04
`define PCS_OFF_IRQ_STATUS 8'h08
`define PCS_OFF_IRQ_MASK 8'h0C

`define PCS_BIT_LVR 5
`define PCS_BIT_PLL_LOCK_CHANGE_FLAG 4
`define PCS_BIT_LOCK 3
`define PCS_BIT_TRACK 2
`define PCS_BIT_SELF_CLOCK_CHANGE_FLAG 1
`define PCS_BIT_SCM 0

`define PCS_FLAGS_RESET 8'h00
`define PCS_ENABLE_RESET 8'h00
`define PCS_MASK_RESET 8'h00

`define PCS_BIT_EN_LOCK 0
`define PCS_BIT_EN_SCM 1

`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2

`endif

//--- hdl/pcs_change_detect.v
/*
 * Change detector: flags a change of a status level.
 * Assumes the level is synchronous to aclk.
 */
`timescale 1ns/1ps
module pcs_change_detect #(
	parameter WIDTH = 2
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] level,
	output reg [WIDTH-1:0] changed
);
	reg [WIDTH-1:0] prev;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					prev[i] <= 1'b0;
					changed[i] <= 1'b0;
				end else begin
					prev[i] <= level[i];
					changed[i] <= level[i] ^ prev[i];
				end
			end
		end
	endgenerate
endmodule

//--- verif/pcs_clock_status_props.sv
/*
 * Port assertions of the clock status block: bus handshakes and flag read data.
 * Assumes a bind to pcs_clock_status, one clock and a synchronous low reset.
 */
`timescale 1ns/1ps
module pcs_clock_status_props (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awready,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held too long");
	chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready held too long");
	chk_ar_rvalid: assert property (s_axi_arready |-> s_axi_rvalid)
		else $error("read data late");
	chk_ar_answer: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[0:3] s_axi_arready)
		else $error("read address not taken");
	chk_b_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	chk_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_scm_forces: assert property (
		s_axi_arready && s_axi_araddr == 8'h00 && s_axi_rdata[0] |-> s_axi_rdata[3:2] == 2'h0)
		else $error("lock or track set in self clock mode");
	chk_irq_quiet: assert property ($rose(aresetn) |-> !irq)
		else $error("irq high after reset");
endmodule

bind pcs_clock_status pcs_clock_status_props i_props (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq);

//--- verif/pcs_clock_status_tb.sv
/*
 * Self-checking bench of the clock status block through its AXI4-Lite port.
 * Assumes the design and the checker file are compiled before it.
 */
`timescale 1ns/1ps
module pcs_clock_status_tb;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, pll_locked = 0, pll_tracking = 0, self_clock_mode = 0;
	logic low_voltage_reset_event = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [31:0] nolvr_rdata;
	int err_count = 0, n_compared = 0;

	pcs_clock_status i_pcs_clock_status (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.pll_locked, .pll_tracking, .self_clock_mode, .low_voltage_reset_event, .irq);

	// Same stimulus into a copy without the feature; only its read data is compared
	pcs_clock_status #(.HAS_LVR(0)) i_pcs_clock_status_nolvr (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(nolvr_rdata), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready, .pll_locked, .pll_tracking, .self_clock_mode,
		.low_voltage_reset_event, .irq());

	always #20 aclk = ~aclk;

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		begin
			n_compared++;
			if (s !== e) begin
				err_count++;
				$display("[ERR] %s expected %h seen %h", n, e, s);
			end
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		begin
			ta = 0;
			tw = 0;
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			while (!(ta && tw)) begin
				@(posedge aclk);
				ta = ta | s_axi_awready;
				tw = tw | s_axi_wready;
				s_axi_awvalid <= !ta;
				s_axi_wvalid <= !tw;
			end
			do @(posedge aclk); while (!s_axi_bvalid);
			s_axi_bready <= 1'b0;
			chk("bresp", 32'(s_axi_bresp), 32'(er));
		end
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do @(posedge aclk); while (!s_axi_arready);
			s_axi_arvalid <= 1'b0;
			while (!s_axi_rvalid) @(posedge aclk);
			s_axi_rready <= 1'b0;
			chk("rdata", s_axi_rdata, e);
			chk("rdata_nolvr", nolvr_rdata, (a == 8'h00) ? (e & 32'hFFFFFFDF) : e);
			chk("rresp", 32'(s_axi_rresp), 32'(er));
		end
	endtask

	// Status, change pulse, flag, then irq: five edges so irq is read settled
	task settle;
		repeat (5) @(posedge aclk);
	endtask

	task end_of_test;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h00, 32'h00, 2'h0);
		rd(8'h04, 32'h00, 2'h0);
		rd(8'h0C, 32'h00, 2'h0);
		rd(8'h10, 32'h00, 2'h2);
		wr(8'h10, 32'hFF, 2'h2);
		$display("test reset and map done");
		wr(8'h04, 32'h01, 2'h0);
		pll_locked <= 1'b1;
		pll_tracking <= 1'b1;
		settle;
		chk("irq", 32'(irq), 32'h1);
		rd(8'h00, 32'h1C, 2'h0);
		wr(8'h00, 32'h00, 2'h0);
		rd(8'h00, 32'h1C, 2'h0);
		wr(8'h00, 32'h1C, 2'h0);
		wr(8'h08, 32'hFF, 2'h0);
		rd(8'h00, 32'h0C, 2'h0);
		chk("irq", 32'(irq), 32'h0);
		$display("test lock done");
		wr(8'h04, 32'h02, 2'h0);
		self_clock_mode <= 1'b1;
		settle;
		chk("irq", 32'(irq), 32'h1);
		rd(8'h00, 32'h13, 2'h0);
		wr(8'h00, 32'h1F, 2'h0);
		wr(8'h08, 32'hFF, 2'h0);
		rd(8'h00, 32'h01, 2'h0);
		chk("irq", 32'(irq), 32'h0);
		$display("test self clock done");
		low_voltage_reset_event <= 1'b1;
		@(posedge aclk);
		low_voltage_reset_event <= 1'b0;
		rd(8'h00, 32'h21, 2'h0);
		wr(8'h00, 32'h00, 2'h0);
		rd(8'h00, 32'h21, 2'h0);
		// Event held across the clearing write so both land on one edge
		low_voltage_reset_event <= 1'b1;
		wr(8'h00, 32'h20, 2'h0);
		low_voltage_reset_event <= 1'b0;
		rd(8'h00, 32'h21, 2'h0);
		wr(8'h00, 32'h20, 2'h0);
		rd(8'h00, 32'h01, 2'h0);
		$display("test low voltage done");
		end_of_test;
	end

	initial begin
		repeat (3000) @(posedge aclk);
		err_count++;
		end_of_test;
	end
endmodule
